// ==== rtl/rsc_top.sv ====
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module rsc_top #(
  parameter int KEY_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic [KEY_W-1:0] key_port_inputs,
  input wire logic wdt_overflow,
  input wire logic internal_oscillator_on,
  input wire logic high_speed_oscillator_on,
  input wire logic sleep_mode,
  input wire logic converter_control_enable,
  input wire logic converter_busy_flag,
  output logic regulator_economy,
  output logic reference_source_on,
  output logic analog_supply_drive,
  output logic periph_reset_n,
  output logic cpu_run,
  output logic wdt_nmi
);
  localparam logic [6:0] CNT_STAB = 7'(`RSC_WAIT_STAB - 1);
  localparam logic [6:0] CNT_CLK = 7'(`RSC_WAIT_CLK - 1);
  localparam logic [6:0] CNT_FLASH = 7'(`RSC_WAIT_FLASH - 1);

  // byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    reg_addr = {14'h0000, idx, 2'b00};
  endfunction

  // pin and asynchronous inputs pass two flip-flops
  logic [KEY_W+5:0] raw_in, syn_in;
  assign raw_in = {key_port_inputs, reset_pin_n, wdt_overflow,
                   internal_oscillator_on, high_speed_oscillator_on,
                   sleep_mode, converter_busy_flag};
  rsc_sync2 #(.WIDTH(KEY_W+6), .INIT({{KEY_W{1'b1}}, 6'h00})) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(raw_in),
    .dout(syn_in)
  );
  logic [KEY_W-1:0] key_s;
  logic pin_s, wdt_s, internal_oscillator_s, high_speed_oscillator_s, sleep_s, busy_s;
  assign key_s = syn_in[KEY_W+5:6];
  assign pin_s = syn_in[5];
  assign wdt_s = syn_in[4];
  assign internal_oscillator_s = syn_in[3];
  assign high_speed_oscillator_s = syn_in[2];
  assign sleep_s = syn_in[1];
  assign busy_s = syn_in[0];

  // register state
  logic [1:0] mode_q, mode_d;
  logic ref_en_q, ref_en_d, aout_en_q, aout_en_d;
  logic key_en_q, key_en_d, wdt_sel_q, wdt_sel_d;
  logic [KEY_W-1:0] key_sel_q, key_sel_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, pready_q;
  logic wr_en, rd_en, hit;
  assign wr_en = psel & penable & pwrite & ~pready_q;
  assign rd_en = psel & penable & ~pwrite & ~pready_q;

  // reset and sequence state
  logic rst_req;
  rsc_pkg::rsc_seq_e seq_q, seq_d;
  logic [6:0] cnt_q, cnt_d;
  logic econ_d, nmi_d;

  // address hit for any mapped register
  always_comb begin
    hit = (paddr == reg_addr(`RSC_IDX_REG_MODE)) ||
          (paddr == reg_addr(`RSC_IDX_ANA_PWR)) ||
          (paddr == reg_addr(`RSC_IDX_RST_CTL)) ||
          (paddr == reg_addr(`RSC_IDX_STATUS));
  end

  // register writes and read mux; one wait state per access
  always_comb begin
    mode_d = mode_q;
    ref_en_d = ref_en_q;
    aout_en_d = aout_en_q;
    key_en_d = key_en_q;
    wdt_sel_d = wdt_sel_q;
    key_sel_d = key_sel_q;
    prdata_d = 32'h0000_0000;
    pready_d = psel & penable & ~pready_q;
    pslverr_d = psel & penable & ~pready_q & ~hit;
    if (wr_en) begin
      if (paddr == reg_addr(`RSC_IDX_REG_MODE)) begin
        mode_d = pwdata[`RSC_MODE_LSB +: 2];
      end
      if (paddr == reg_addr(`RSC_IDX_ANA_PWR)) begin
        ref_en_d = pwdata[`RSC_REF_EN_BIT];
        aout_en_d = pwdata[`RSC_AOUT_EN_BIT];
      end
      if (paddr == reg_addr(`RSC_IDX_RST_CTL)) begin
        key_sel_d = pwdata[KEY_W-1:0];
        key_en_d = pwdata[`RSC_KEY_EN_BIT];
        wdt_sel_d = pwdata[`RSC_WDT_SEL_BIT];
      end
    end
    if (rd_en) begin
      // unlisted bits stay zero
      if (paddr == reg_addr(`RSC_IDX_REG_MODE)) begin
        prdata_d[`RSC_MODE_LSB +: 2] = mode_q;
      end
      if (paddr == reg_addr(`RSC_IDX_ANA_PWR)) begin
        prdata_d[`RSC_REF_EN_BIT] = ref_en_q;
        prdata_d[`RSC_AOUT_EN_BIT] = aout_en_q;
      end
      if (paddr == reg_addr(`RSC_IDX_RST_CTL)) begin
        prdata_d[KEY_W-1:0] = key_sel_q;
        prdata_d[`RSC_KEY_EN_BIT] = key_en_q;
        prdata_d[`RSC_WDT_SEL_BIT] = wdt_sel_q;
      end
      if (paddr == reg_addr(`RSC_IDX_STATUS)) begin
        prdata_d[0] = cpu_run;
        prdata_d[1] = regulator_economy;
        prdata_d[2] = pin_s;
        // converter state, so software can see it is idle
        prdata_d[3] = converter_control_enable;
        prdata_d[4] = busy_s;
      end
    end
  end

  // register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `RSC_MODE_RST;
      ref_en_q <= 1'b0;
      aout_en_q <= 1'b0;
      key_en_q <= 1'b0;
      wdt_sel_q <= 1'b0;
      key_sel_q <= '0;
      prdata <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr <= 1'b0;
    end else if (rst_req) begin
      // internal reset reinitialises the register file
      mode_q <= `RSC_MODE_RST;
      ref_en_q <= 1'b0;
      aout_en_q <= 1'b0;
      key_en_q <= 1'b0;
      wdt_sel_q <= 1'b0;
      key_sel_q <= '0;
      prdata <= prdata_d;
      pready_q <= pready_d;
      pslverr <= pslverr_d;
    end else begin
      mode_q <= mode_d;
      ref_en_q <= ref_en_d;
      aout_en_q <= aout_en_d;
      key_en_q <= key_en_d;
      wdt_sel_q <= wdt_sel_d;
      key_sel_q <= key_sel_d;
      prdata <= prdata_d;
      pready_q <= pready_d;
      pslverr <= pslverr_d;
    end
  end
  assign pready = pready_q;

  // combined reset request from the three sources
  always_comb begin
    rst_req = ~pin_s
      | (key_en_q & (key_sel_q != '0) & ((key_s & key_sel_q) == '0))
      | (wdt_s & wdt_sel_q);
  end

  // post-release sequence and regulator mode
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    if (rst_req) begin
      seq_d = rsc_pkg::RSC_SEQ_STAB;
      cnt_d = CNT_STAB;
    end else if (seq_q != rsc_pkg::RSC_SEQ_RUN) begin
      if (cnt_q != 7'h00) begin
        cnt_d = cnt_q - 7'h01;
      end else begin
        unique case (seq_q)
          rsc_pkg::RSC_SEQ_STAB: begin
            seq_d = rsc_pkg::RSC_SEQ_CLK;
            cnt_d = CNT_CLK;
          end
          rsc_pkg::RSC_SEQ_CLK: begin
            seq_d = rsc_pkg::RSC_SEQ_FLASH;
            cnt_d = CNT_FLASH;
          end
          rsc_pkg::RSC_SEQ_FLASH: begin
            seq_d = rsc_pkg::RSC_SEQ_RUN;
          end
          rsc_pkg::RSC_SEQ_RUN: begin
            seq_d = rsc_pkg::RSC_SEQ_RUN;
          end
        endcase
      end
    end
    unique case (rsc_pkg::rsc_mode_e'(mode_q))
      rsc_pkg::RSC_MODE_ECO: econ_d = 1'b1;
      rsc_pkg::RSC_MODE_AUTO: econ_d = (~internal_oscillator_s & ~high_speed_oscillator_s) | sleep_s;
      rsc_pkg::RSC_MODE_NORMAL: econ_d = 1'b0;
      rsc_pkg::RSC_MODE_RSVD: econ_d = 1'b0;
    endcase
    nmi_d = wdt_s & ~wdt_sel_q;
  end

  // sequence and output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= rsc_pkg::RSC_SEQ_STAB;
      cnt_q <= CNT_STAB;
      periph_reset_n <= 1'b0;
      cpu_run <= 1'b0;
      regulator_economy <= 1'b0;
      reference_source_on <= 1'b0;
      analog_supply_drive <= 1'b0;
      wdt_nmi <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      periph_reset_n <= ~rst_req;
      cpu_run <= (seq_d == rsc_pkg::RSC_SEQ_RUN);
      regulator_economy <= econ_d;
      reference_source_on <= ref_en_q;
      analog_supply_drive <= aout_en_q;
      wdt_nmi <= nmi_d;
    end
  end

  // cycles since the last internal reset, for the boot wait check
  localparam logic [6:0] BOOT_TOTAL =
    7'(`RSC_WAIT_STAB + `RSC_WAIT_CLK + `RSC_WAIT_FLASH);
  logic [6:0] boot_cnt_q, boot_cnt_d;
  // saturating count of reset-free cycles
  always_comb begin
    boot_cnt_d = boot_cnt_q;
    if (rst_req) begin
      boot_cnt_d = 7'h00;
    end else if (boot_cnt_q != 7'h7f) begin
      boot_cnt_d = boot_cnt_q + 7'h01;
    end
  end
  // boot wait counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt_q <= 7'h00;
    end else begin
      boot_cnt_q <= boot_cnt_d;
    end
  end

  // checks
  a_rst_holds_cpu: assert property (@(posedge pclk)
    disable iff (!presetn) rst_req |=> !cpu_run && !periph_reset_n)
    else $error("cpu runs during reset");
  a_pin_reset: assert property (@(posedge pclk)
    disable iff (!presetn) !pin_s |=> !periph_reset_n)
    else $error("pin low did not reset");
  a_wait_total: assert property (@(posedge pclk)
    disable iff (!presetn) cpu_run == (boot_cnt_q >= BOOT_TOTAL))
    else $error("boot wait length wrong");
  a_no_early_run: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(rst_req) |-> ##100 (!cpu_run || rst_req))
    else $error("boot too early");
  a_auto_eco: assert property (@(posedge pclk)
    disable iff (!presetn)
    (mode_q == 2'h2 && sleep_s && !rst_req) |=> regulator_economy)
    else $error("auto mode not economy in sleep");
  a_normal_mode: assert property (@(posedge pclk)
    disable iff (!presetn) (mode_q == 2'h0) |=> !regulator_economy)
    else $error("normal mode shows economy");
  a_wdt_nmi: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wdt_s && !wdt_sel_q && pin_s && !key_en_q)
    |=> wdt_nmi && periph_reset_n)
    else $error("watchdog nmi missing");
  a_ref_follow: assert property (@(posedge pclk)
    disable iff (!presetn) ##1 reference_source_on == $past(ref_en_q))
    else $error("reference enable lost");
  a_aout_follow: assert property (@(posedge pclk)
    disable iff (!presetn) ##1 analog_supply_drive == $past(aout_en_q))
    else $error("analog output enable lost");
  a_rsvd_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_en && paddr == reg_addr(`RSC_IDX_ANA_PWR))
    |=> prdata[31:4] == 0 && prdata[1:0] == 0)
    else $error("reserved bits read nonzero");
  c_boot: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(cpu_run));
  c_key_reset: cover property (@(posedge pclk) disable iff (!presetn)
    key_en_q && rst_req && pin_s);
  c_wdt_reset: cover property (@(posedge pclk) disable iff (!presetn)
    wdt_s && wdt_sel_q);
endmodule
`default_nettype wire

// ==== rtl/rsc_params.svh ====
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
// printed offsets, kept as register indices; byte address is four times
`define RSC_IDX_REG_MODE 16'h5121
`define RSC_IDX_ANA_PWR 16'h550a
`define RSC_IDX_RST_CTL 16'h0001
`define RSC_IDX_STATUS 16'h0002
// field positions
`define RSC_MODE_LSB 0
`define RSC_REF_EN_BIT 3
`define RSC_AOUT_EN_BIT 2
`define RSC_KEY_EN_BIT 4
`define RSC_WDT_SEL_BIT 5
// reset values
`define RSC_MODE_RST 2'h0
`define RSC_ANA_RST 2'h0
`define RSC_KEY_SEL_RST 4'h0
// post-release waits, in pclk cycles
`define RSC_WAIT_STAB 64
`define RSC_WAIT_CLK 8
`define RSC_WAIT_FLASH 32
`endif

// ==== rtl/rsc_pkg.sv ====
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_MODE_NORMAL = 2'h0,
    RSC_MODE_ECO = 2'h1,
    RSC_MODE_AUTO = 2'h2,
    RSC_MODE_RSVD = 2'h3
  } rsc_mode_e;
  typedef enum logic [1:0] {
    RSC_SEQ_STAB = 2'h0,
    RSC_SEQ_CLK = 2'h1,
    RSC_SEQ_FLASH = 2'h2,
    RSC_SEQ_RUN = 2'h3
  } rsc_seq_e;
endpackage

// ==== rtl/rsc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for a bundle of levels
module rsc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      dout <= INIT;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== verif/rsc_board.sv ====
`timescale 1ns/1ps
`default_nettype none
// board reset circuit: pulled-up pin and a pushbutton that holds it low
module rsc_board #(
  parameter int HOLD = 12
) (
  input wire logic pclk,
  output logic reset_pin_n
);
  // pin starts low after the supply comes on, then the pull-up wins
  initial begin
    reset_pin_n = 1'b0;
    repeat (HOLD) @(posedge pclk);
    reset_pin_n <= 1'b1;
  end
  // press for n cycles, never shorter than the settling time
  task automatic press(input int n);
    reset_pin_n <= 1'b0;
    repeat ((n < HOLD) ? HOLD : n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module tb;
  localparam logic [31:0] A_MODE = 32'({`RSC_IDX_REG_MODE, 2'b00});
  localparam logic [31:0] A_ANA = 32'({`RSC_IDX_ANA_PWR, 2'b00});
  localparam logic [31:0] A_RST = 32'h4;
  localparam logic [31:0] A_STAT = 32'h8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, er, reset_pin_n, wdt_overflow = 0;
  logic osc_i = 1, osc_h = 1, sleep_mode = 0, econ, ref_on, a_drv;
  logic prst_n, cpu_run, nmi;
  logic [3:0] keys = 4'hf;
  logic conv_en = 0, conv_busy = 0;
  int n_errors = 0, checks = 0, cycles = 0, n;
  rsc_board u_board (.pclk(pclk), .reset_pin_n(reset_pin_n));
  rsc_top u_rsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .key_port_inputs(keys),
    .wdt_overflow(wdt_overflow), .internal_oscillator_on(osc_i),
    .high_speed_oscillator_on(osc_h), .sleep_mode(sleep_mode),
    .converter_control_enable(conv_en), .converter_busy_flag(conv_busy),
    .regulator_economy(econ), .reference_source_on(ref_on),
    .analog_supply_drive(a_drv), .periph_reset_n(prst_n),
    .cpu_run(cpu_run), .wdt_nmi(nmi));
  always #4 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access until pready, release
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_rst(input logic v);
    n = 0;
    while (prst_n !== v && n < 20) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic wait_run();
    n = 0;
    while (cpu_run !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic t_regs();
    apb(0, A_MODE, 0);
    chk(rd, 32'h0);
    apb(0, A_ANA, 0);
    chk(rd, 32'h0);
    apb(0, A_STAT, 0);
    chk(rd, 32'h5);
    conv_en <= 1'b1;
    conv_busy <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, A_STAT, 0);
    chk(rd, 32'h1d);
    conv_en <= 1'b0;
    conv_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1, A_ANA, 32'hc);
    apb(0, A_ANA, 0);
    chk(rd, 32'hc);
    chk({ref_on, a_drv}, 32'h3);
    apb(1, A_ANA, 32'h8);
    repeat (2) @(posedge pclk);
    chk({ref_on, a_drv}, 32'h2);
    apb(1, A_ANA, 32'h0);
    apb(0, 32'h10, 0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask
  // mode, internal_oscillator, hs osc, sleep, expected economy
  task automatic t_modes();
    logic [5:0] tv [8] = '{6'h0c, 6'h11, 6'h3c, 6'h2c, 6'h24, 6'h28,
      6'h21, 6'h2f};
    foreach (tv[i]) begin
      apb(1, A_MODE, 32'(tv[i][5:4]));
      {osc_i, osc_h, sleep_mode} <= tv[i][3:1];
      repeat (5) @(posedge pclk);
      chk(econ, tv[i][0]);
    end
    {osc_i, osc_h, sleep_mode} <= 3'b110;
    $display("t_modes done");
  endtask
  task automatic t_pin();
    apb(1, A_MODE, 32'h2);
    u_board.press(20);
    chk({prst_n, cpu_run}, 32'h0);
    wait_rst(1'b1);
    wait_run();
    chk(n >= 103 && n <= 106, 32'h1);
    apb(0, A_MODE, 0);
    chk(rd, 32'h0);
    $display("t_pin done");
  endtask
  task automatic t_wdt();
    apb(1, A_RST, 32'h0);
    wdt_overflow <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({nmi, prst_n}, 32'h3);
    wdt_overflow <= 1'b0;
    apb(1, A_RST, 32'h20);
    chk(nmi, 32'h0);
    wdt_overflow <= 1'b1;
    wait_rst(1'b0);
    chk(prst_n, 32'h0);
    wdt_overflow <= 1'b0;
    wait_run();
    chk(cpu_run, 32'h1);
    $display("t_wdt done");
  endtask
  task automatic t_key();
    apb(1, A_RST, 32'h3);
    keys <= 4'h0;
    repeat (6) @(posedge pclk);
    chk(prst_n, 32'h1);
    keys <= 4'hd;
    repeat (3) @(posedge pclk);
    apb(1, A_RST, 32'h13);
    repeat (6) @(posedge pclk);
    chk(prst_n, 32'h1);
    keys <= 4'hc;
    wait_rst(1'b0);
    chk(prst_n, 32'h0);
    keys <= 4'hf;
    wait_run();
    chk(cpu_run, 32'h1);
    $display("t_key done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    t_regs();
    t_modes();
    t_pin();
    t_wdt();
    t_key();
    stop_test();
  end
endmodule
`default_nettype wire
